// ---- ocf_pkg.sv ----
// Package of constants and types for the overcurrent fault retry controller.
package ocf_pkg;

  // Command codes of the registers held by this block.
  localparam logic [7:0] CMD_OC_LIMIT    = 8'h46;
  localparam logic [7:0] CMD_OC_RESPONSE = 8'h47;
  localparam logic [7:0] CMD_OC_LV_LIMIT = 8'h48;

  // Field positions inside the response register.
  localparam int RSP_MODE_HI  = 7;
  localparam int RSP_MODE_LO  = 6;
  localparam int RSP_RETRY_HI = 5;
  localparam int RSP_RETRY_LO = 3;
  localparam int RSP_DELAY_HI = 2;
  localparam int RSP_DELAY_LO = 0;

  // Reset values.
  localparam logic [15:0] OC_LIMIT_RESET = 16'hffff;
  localparam logic [7:0]  OC_RSP_RESET   = 8'hc0;
  localparam logic [15:0] OC_LV_RESET    = 16'h0000;

  // Response modes.
  localparam logic [1:0] MODE_IGNORE   = 2'h0;
  localparam logic [1:0] MODE_CONTINUE = 2'h1;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h2;
  localparam logic [1:0] MODE_RETRY    = 2'h3;

  // Retry codes with special meaning.
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Widths of counters.
  localparam int UNIT_W  = 16;
  localparam int DELAY_W = 8;

  // Controller states.
  typedef enum logic [2:0] {
    OCF_RUN,
    OCF_CONT,
    OCF_WAIT,
    OCF_TRY,
    OCF_LOCK
  } ocf_state_t;

  // Register write request from the command decoder.
  typedef struct packed {
    logic       wr;
    logic [7:0] cmd;
    logic [15:0] data;
  } ocf_wr_t;

endpackage : ocf_pkg

// ---- ocf_delay.sv ----
// Delay generator that counts a power of two of delay units.
`timescale 1ns/1ps
`default_nettype none
module ocf_delay (
  // Clock and reset.
  input  wire logic                      clk_in,
  input  wire logic                      rst_in,
  // Control.
  input  wire logic                      start_in,
  input  wire logic                      abort_in,
  input  wire logic [2:0]                code_in,
  input  wire logic [ocf_pkg::UNIT_W-1:0] unit_cycles_in,
  // Status.
  output logic                           done_out,
  output logic                           busy_out
);

  logic [ocf_pkg::UNIT_W-1:0]  unit_q;
  logic [ocf_pkg::DELAY_W-1:0] units_q;
  logic                        unit_tick;

  // One-cycle pulse at the end of each delay unit.
  assign unit_tick = busy_out && (unit_q == ocf_pkg::UNIT_W'(0));

  // Counts cycles inside the current unit.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      unit_q <= '0;
    end else if (start_in || abort_in || unit_tick) begin
      unit_q <= (unit_cycles_in == '0) ? '0 : unit_cycles_in - ocf_pkg::UNIT_W'(1);
    end else if (busy_out) begin
      unit_q <= unit_q - ocf_pkg::UNIT_W'(1);
    end
  end

  // Counts remaining units; code n gives two to the n units.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      units_q  <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (abort_in) begin
        busy_out <= 1'b0;
      end else if (start_in) begin
        units_q  <= ocf_pkg::DELAY_W'(1) << code_in;
        busy_out <= 1'b1;
      end else if (unit_tick) begin
        units_q <= units_q - ocf_pkg::DELAY_W'(1);
        if (units_q == ocf_pkg::DELAY_W'(1)) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end

endmodule // ocf_delay
`default_nettype wire

// ---- ocf_ctrl.sv ----
// Overcurrent fault limits, response decode and retry control.
//
// Contract
// - Retry codes one to six restart that often, then stay off until cleared.
// - Retry code seven restarts forever until off command or other shutdown.
// - Restart attempts start one delay apart, delay count times delay unit.
// - Delay code n means two to the n delay units.
// - Delay serves as continue time or restart spacing, by response.
// - Delay unit length comes from a separate configuration input.
// - Hold 16-bit overcurrent limit at 0x46, compared against measured current.
// - Every response sets the fault status bit and notifies the host.
// - Response code 11 shuts down and follows the retry count.
// - Retry count zero attempts no restart; output stays off until cleared.
// - Retries field bits 5:3 sets number of restart attempts.
// - Hold 16-bit unsigned low-voltage overcurrent threshold at 0x48.
// - Fault clears by bit clear, clear command, reset, off-on cycle, bias loss.
// - Continue response runs for the delay, then acts on the retry setting.
`timescale 1ns/1ps
`default_nettype none
module ocf_ctrl (
  // Clock and reset.
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  // Register access from the command decoder.
  input  wire ocf_pkg::ocf_wr_t           wr_in,
  input  wire logic [7:0]                 rd_cmd_in,
  output logic [15:0]                     rd_data_out,
  // Delay unit length in clock cycles.
  input  wire logic [ocf_pkg::UNIT_W-1:0] unit_cycles_in,
  // Measurements and fault source.
  input  wire logic [15:0]                iout_in,
  input  wire logic [15:0]                vout_in,
  // Fault clearing and output command.
  input  wire logic                       clear_bit_in,
  input  wire logic                       clear_faults_in,
  input  wire logic                       on_cmd_in,
  input  wire logic                       bias_ok_in,
  input  wire logic                       other_shutdown_in,
  // Power stage and status.
  output logic                            output_en_out,
  output logic                            fault_status_out,
  output logic                            lv_fault_out,
  output logic                            host_notify_out,
  output logic [2:0]                      attempts_out
);

  logic [15:0]         limit_q;
  logic [7:0]          rsp_q;
  logic [15:0]         lv_q;
  ocf_pkg::ocf_state_t state_q;
  logic                on_s1_q;
  logic                on_q;
  logic                bias_s1_q;
  logic                bias_q;
  logic                on_prev_q;
  logic                oc_now;
  logic                fault_hit;
  logic                clear_evt;
  logic [1:0]          mode;
  logic [2:0]          retries;
  logic                dly_start;
  logic                dly_abort;
  logic                dly_done;
  logic                give_up;

  // Fields of the response register.
  assign mode    = rsp_q[ocf_pkg::RSP_MODE_HI:ocf_pkg::RSP_MODE_LO];
  assign retries = rsp_q[ocf_pkg::RSP_RETRY_HI:ocf_pkg::RSP_RETRY_LO];

  // Overcurrent compare on measured current, and detection of a new fault.
  assign oc_now    = (iout_in > limit_q);
  assign fault_hit = oc_now && !fault_status_out;

  // Any event that clears the latched fault; it is refused while the overcurrent persists.
  assign clear_evt = (clear_bit_in || clear_faults_in || !bias_q
                   || (on_q && !on_prev_q)) && !oc_now;

  // Further retries are exhausted unless the count is unlimited.
  assign give_up = (retries != ocf_pkg::RETRY_FOREVER)
                && (attempts_out >= retries);

  // Synchronise asynchronous command and bias levels.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      on_s1_q   <= 1'b0;
      on_q      <= 1'b0;
      bias_s1_q <= 1'b0;
      bias_q    <= 1'b0;
      on_prev_q <= 1'b0;
    end else begin
      on_s1_q   <= on_cmd_in;
      on_q      <= on_s1_q;
      bias_s1_q <= bias_ok_in;
      bias_q    <= bias_s1_q;
      on_prev_q <= on_q;
    end
  end

  // Register writes.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      limit_q <= ocf_pkg::OC_LIMIT_RESET;
      rsp_q   <= ocf_pkg::OC_RSP_RESET;
      lv_q    <= ocf_pkg::OC_LV_RESET;
    end else if (wr_in.wr) begin
      case (wr_in.cmd)
        ocf_pkg::CMD_OC_LIMIT:    limit_q <= wr_in.data;
        ocf_pkg::CMD_OC_RESPONSE: rsp_q   <= wr_in.data[7:0];
        ocf_pkg::CMD_OC_LV_LIMIT: lv_q    <= wr_in.data;
        default: ;
      endcase
    end
  end

  // Register reads; unknown codes read as zero.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
    end else begin
      case (rd_cmd_in)
        ocf_pkg::CMD_OC_LIMIT:    rd_data_out <= limit_q;
        ocf_pkg::CMD_OC_RESPONSE: rd_data_out <= {8'h00, rsp_q};
        ocf_pkg::CMD_OC_LV_LIMIT: rd_data_out <= lv_q;
        default:                  rd_data_out <= '0;
      endcase
    end
  end

  // Low-voltage overcurrent: current over limit while voltage is under the unsigned threshold.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lv_fault_out <= 1'b0;
    end else begin
      lv_fault_out <= oc_now && (vout_in < lv_q);
    end
  end

  // Sticky fault status and one-cycle host notification; a new fault wins over a clear.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_status_out <= 1'b0;
      host_notify_out  <= 1'b0;
    end else begin
      host_notify_out <= fault_hit;
      if (oc_now) begin
        fault_status_out <= 1'b1;
      end else if (clear_evt) begin
        fault_status_out <= 1'b0;
      end
    end
  end

  // Delay engine starts on entry to a continue or wait period.
  always_comb begin
    dly_start = 1'b0;
    case (state_q)
      ocf_pkg::OCF_RUN: begin
        dly_start = oc_now && bias_q && on_q
                 && ((mode == ocf_pkg::MODE_CONTINUE)
                  || (((mode == ocf_pkg::MODE_SHUTDOWN) || (mode == ocf_pkg::MODE_RETRY))
                      && (retries != ocf_pkg::RETRY_NONE)));
      end
      ocf_pkg::OCF_CONT: dly_start = dly_done && oc_now && !give_up;
      ocf_pkg::OCF_TRY:  dly_start = oc_now && !give_up;
      default:           dly_start = 1'b0;
    endcase
  end
  assign dly_abort = !on_q || !bias_q || other_shutdown_in;

  // Delay generator in units from the separate unit setting.
  ocf_delay u_delay (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .start_in       (dly_start),
    .abort_in       (dly_abort),
    .code_in        (rsp_q[ocf_pkg::RSP_DELAY_HI:ocf_pkg::RSP_DELAY_LO]),
    .unit_cycles_in (unit_cycles_in),
    .done_out       (dly_done),
    .busy_out       ()
  );

  // Response state machine.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ocf_pkg::OCF_RUN;
    end else if (dly_abort) begin
      state_q <= ocf_pkg::OCF_RUN;
    end else begin
      case (state_q)
        ocf_pkg::OCF_RUN: begin
          if (oc_now) begin
            case (mode)
              ocf_pkg::MODE_IGNORE:   state_q <= ocf_pkg::OCF_RUN;
              ocf_pkg::MODE_CONTINUE: state_q <= ocf_pkg::OCF_CONT;
              default: begin
                state_q <= (retries == ocf_pkg::RETRY_NONE) ? ocf_pkg::OCF_LOCK
                                                            : ocf_pkg::OCF_WAIT;
              end
            endcase
          end
        end
        ocf_pkg::OCF_CONT: begin
          if (dly_done) begin
            if (!oc_now) begin
              state_q <= ocf_pkg::OCF_RUN;
            end else begin
              state_q <= give_up ? ocf_pkg::OCF_LOCK : ocf_pkg::OCF_WAIT;
            end
          end
        end
        ocf_pkg::OCF_WAIT: begin
          if (dly_done) begin
            state_q <= ocf_pkg::OCF_TRY;
          end
        end
        ocf_pkg::OCF_TRY: begin
          if (!oc_now) begin
            state_q <= ocf_pkg::OCF_RUN;
          end else begin
            state_q <= give_up ? ocf_pkg::OCF_LOCK : ocf_pkg::OCF_WAIT;
          end
        end
        ocf_pkg::OCF_LOCK: begin
          if (clear_evt) begin
            state_q <= ocf_pkg::OCF_RUN;
          end
        end
        default: state_q <= ocf_pkg::OCF_RUN;
      endcase
    end
  end

  // Attempt counter; counts restarts, restarts from zero on a clear or off-on cycle.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      attempts_out <= '0;
    end else if (clear_evt || !on_q) begin
      attempts_out <= '0;
    end else if ((state_q == ocf_pkg::OCF_WAIT) && dly_done && (attempts_out != 3'h7)) begin
      attempts_out <= attempts_out + 3'h1;
    end
  end

  // Output enable: on while running, continuing or trying a restart.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      output_en_out <= 1'b0;
    end else begin
      output_en_out <= on_q && bias_q && !other_shutdown_in
                    && ((state_q == ocf_pkg::OCF_RUN) || (state_q == ocf_pkg::OCF_CONT)
                     || (state_q == ocf_pkg::OCF_TRY) || (dly_done && state_q == ocf_pkg::OCF_WAIT));
    end
  end

endmodule // ocf_ctrl
`default_nettype wire

// ---- ocf_ctrl_assertions.sv ----
// Port assertions for the overcurrent fault controller.
`timescale 1ns/1ps
`default_nettype none
module ocf_ctrl_assertions (
  // Clock and reset.
  input wire logic             clk_in,
  input wire logic             rst_in,
  // Register access.
  input wire ocf_pkg::ocf_wr_t wr_in,
  input wire logic [7:0]       rd_cmd_in,
  input wire logic [15:0]      rd_data_out,
  // Control and status.
  input wire logic             bias_ok_in,
  input wire logic             other_shutdown_in,
  input wire logic             output_en_out,
  input wire logic             fault_status_out,
  input wire logic             lv_fault_out,
  input wire logic             host_notify_out,
  input wire logic [2:0]       attempts_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // A limit write, one idle cycle, then a read of it.
  sequence s_wr_rd;
    wr_in.wr && wr_in.cmd == 8'h46 ##1 !wr_in.wr ##1 rd_cmd_in == 8'h46 && !wr_in.wr;
  endsequence
  // The start of a new restart attempt.
  sequence s_try;
    $changed(attempts_out) && attempts_out != 3'h0;
  endsequence
  notify_pulse_a: assert property (host_notify_out |=> !host_notify_out)
    else $error("notify pulse too long");
  notify_fault_a: assert property (host_notify_out |-> fault_status_out)
    else $error("notify without fault bit");
  lv_fault_a: assert property (lv_fault_out |-> fault_status_out)
    else $error("low voltage flag without fault");
  write_read_a: assert property (s_wr_rd |=> rd_data_out == $past(wr_in.data, 3))
    else $error("limit read back wrong");
  unmapped_zero_a: assert property (!(rd_cmd_in inside {[8'h46:8'h48]}) |=> rd_data_out == 16'h0000)
    else $error("unmapped read not zero");
  bias_off_a: assert property (!bias_ok_in [*4] |-> !output_en_out)
    else $error("output on without bias");
  shut_off_a: assert property (other_shutdown_in [*2] |-> !output_en_out)
    else $error("output on during shutdown");
  retry_on_a: assert property (s_try |-> ##[0:2] output_en_out)
    else $error("restart did not enable output");
endmodule // ocf_ctrl_assertions
bind ocf_ctrl ocf_ctrl_assertions u_chk (.clk_in(clk_in), .rst_in(rst_in), .wr_in(wr_in),
  .rd_cmd_in(rd_cmd_in), .rd_data_out(rd_data_out), .bias_ok_in(bias_ok_in),
  .other_shutdown_in(other_shutdown_in), .output_en_out(output_en_out), .fault_status_out(fault_status_out),
  .lv_fault_out(lv_fault_out), .host_notify_out(host_notify_out), .attempts_out(attempts_out));
`default_nettype wire

// ---- ocf_host.sv ----
// Host model that issues register writes and reads.
`timescale 1ns/1ps
`default_nettype none
module ocf_host (
  // Clock.
  input  wire logic           clk_in,
  // Register access.
  output var ocf_pkg::ocf_wr_t wr_out,
  output logic [7:0]          rd_cmd_out,
  input  wire logic [15:0]    rd_data_in
);
  // Idle request lines from time zero.
  initial begin
    wr_out = '0;
    rd_cmd_out = 8'hff;
  end
  // One write held over one rising edge, then data scrambled.
  task automatic write(input logic [7:0] cmd, input logic [15:0] data);
    @(negedge clk_in);
    wr_out = '{wr: 1'b1, cmd: cmd, data: data};
    @(negedge clk_in);
    wr_out.wr = 1'b0;
    wr_out.data = ~data;
  endtask
  // One read; data is registered one cycle after the code.
  task automatic read(input logic [7:0] cmd, output logic [15:0] data);
    @(negedge clk_in);
    rd_cmd_out = cmd;
    @(negedge clk_in);
    data = rd_data_in;
  endtask
endmodule // ocf_host
`default_nettype wire

// ---- overcurrent_fault_retry_control_test.sv ----
// Self-checking bench for the overcurrent fault retry controller.
`timescale 1ns/1ps
`default_nettype none
module overcurrent_fault_retry_control_test;
  logic             clk_in = 1'b0;
  logic             rst_in = 1'b1;
  ocf_pkg::ocf_wr_t wr;
  logic [7:0]       rd_cmd;
  logic [15:0]      rd_data, rd, iout = '0, vout = 16'h7fff, unit = 16'h1;
  logic             clr = 0, clr_bit = 0, on = 1, bias = 1, shut = 0, pen = 0;
  logic             en, flt, lv, ntf;
  logic [2:0]       att;
  logic [7:0]       rsps [11] = '{8'hc0, 8'hcf, 8'hd2, 8'hd9, 8'he0, 8'he9, 8'hf0, 8'hfa, 8'h91, 8'h43, 8'h03};
  int               bad_count = 0, n_checks = 0, seed = 32'h4008feee;
  int               cyc = 0, last, rises, ntfs, gap_bad, dly, r, m, c;
  int               regs [int];
  // Free-running 50 MHz clock.
  initial forever #10 clk_in = ~clk_in;
  ocf_ctrl DUT (.clk_in(clk_in), .rst_in(rst_in), .wr_in(wr), .rd_cmd_in(rd_cmd), .rd_data_out(rd_data),
    .unit_cycles_in(unit), .iout_in(iout), .vout_in(vout), .clear_bit_in(clr_bit), .clear_faults_in(clr),
    .on_cmd_in(on), .bias_ok_in(bias), .other_shutdown_in(shut), .output_en_out(en),
    .fault_status_out(flt), .lv_fault_out(lv), .host_notify_out(ntf), .attempts_out(att));
  ocf_host HOST (.clk_in(clk_in), .wr_out(wr), .rd_cmd_out(rd_cmd), .rd_data_in(rd_data));
  // Counts enable rises and notify pulses, and checks restart spacing.
  always @(negedge clk_in) begin
    cyc++;
    if (ntf === 1'b1) ntfs++;
    if (en === 1'b1 && pen !== 1'b1) begin
      if (rises > 0 && (cyc - last < dly || cyc - last > dly + 3)) gap_bad++;
      rises++;
      last = cyc;
    end
    pen = en;
  end
  // Compares one value and reports a mismatch.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // Writes a register and updates the model.
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    HOST.write(a, d);
    if (a inside {8'h46, 8'h48}) regs[a] = d;
    if (a == 8'h47) regs[a] = d[7:0];
  endtask
  // Reads a register and compares it with the model.
  task automatic rd_chk(input logic [7:0] a);
    HOST.read(a, rd);
    check("register", rd, regs.exists(a) ? regs[a] : 0);
  endtask
  // One fault episode, a refused clear, then a clear by method k.
  task automatic episode(input logic [7:0] rsp, input int k);
    m = rsp[7:6];
    r = rsp[5:3];
    wr_reg(8'h47, {8'h00, rsp});
    dly = (1 << rsp[2:0]) * unit;
    rises = 0;
    ntfs = 0;
    gap_bad = 0;
    iout = 16'h5000;
    repeat (2) @(negedge clk_in);
    check("enable held", en, m < 2);
    check("lv flag", lv, 1);
    repeat ((r == 7 ? 10 : r + 1) * (dly + 4) + 8) @(negedge clk_in);
    check("fault bit", flt, 1);
    check("notified", ntfs > 0, 1);
    check("gaps", gap_bad, 0);
    if (m < 2) check("rises", rises, 0);
    else if (r == 7) check("forever", rises > 7, 1);
    else check("rises", rises, r);
    if (r != 7) check("attempts", att, m < 2 ? 0 : r);
    if (r != 7 || m < 2) check("locked", en, m == 0);
    clr = 1;
    repeat (3) @(negedge clk_in);
    check("clear refused", flt, 1);
    iout = 16'h1000;
    clr = (k == 0);
    clr_bit = (k == 2);
    on = (k != 1);
    repeat (6) @(negedge clk_in);
    check("off", en, k != 1);
    {clr, clr_bit, on} = 3'b001;
    repeat (8) @(negedge clk_in);
    check("cleared", {flt, lv, att, en}, 6'h01);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Main sequence.
  initial begin
    regs[8'h46] = 16'hffff;
    regs[8'h47] = 16'h00c0;
    regs[8'h48] = 16'h0000;
    repeat (20) @(negedge clk_in);
    rst_in = 0;
    repeat (6) @(negedge clk_in);
    check("power on", en, 1);
    for (int a = 8'h45; a < 8'h4a; a++) rd_chk(a[7:0]);
    repeat (8) begin
      c = 8'h46 + ($random(seed) & 3);
      wr_reg(c[7:0], 16'($random(seed)));
      rd_chk(c[7:0]);
      rd_chk(8'h47);
    end
    wr_reg(8'h46, 16'h4000);
    rd_chk(8'h46);
    wr_reg(8'h48, 16'h8000 | 16'($random(seed)));
    foreach (rsps[i]) begin
      unit = 16'(1 + ($random(seed) & 1));
      episode(rsps[i], i % 3);
    end
    bias = 0;
    repeat (6) @(negedge clk_in);
    check("bias lost", en, 0);
    bias = 1;
    shut = 1;
    repeat (4) @(negedge clk_in);
    check("shut", en, 0);
    shut = 0;
    // A reset in mid-run clears the latched fault and restores the register defaults.
    iout = 16'h5000;
    repeat (3) @(negedge clk_in);
    iout = 16'h1000;
    rst_in = 1;
    repeat (2) @(negedge clk_in);
    rst_in = 0;
    check("reset clears", flt, 0);
    regs[8'h46] = 16'hffff;
    regs[8'h47] = 16'h00c0;
    regs[8'h48] = 16'h0000;
    rd_chk(8'h46);
    rd_chk(8'h47);
    repeat (4) @(negedge clk_in);
    check("reset enable", en, 1);
    end_of_test();
  end
  // Watchdog far beyond the expected run time.
  initial begin
    #1000000;
    bad_count++;
    end_of_test();
  end
endmodule // overcurrent_fault_retry_control_test
`default_nettype wire
